// file: verilog/csss_top.sv
// Overview of operation
// - Fuse code 1001 selects the low-frequency watch crystal as source.
// - Low-frequency crystal with option fuse programmed enables internal pin capacitors.
// - Crystal start-up codes give 1K/4K, 1K/64K, 32K/64K; code 11 reserved.
// - Codes 0101 to 1000 select external RC, four rising frequency ranges.
// - External RC start-up: 18 cycles with none/4K/64K, or 6 with 4K.
// - Codes 0001 to 0100 select internal RC at 1, 2, 4, 8 MHz.
// - Internal RC wakes in 6 cycles; reset delay none/4K/64K; 11 reserved.
// - Reset copies signature byte at address 0x00 into the trim register.
// - Eight-bit trim value sets internal RC frequency, zero lowest, ones highest.
// - Reset delay is timed by the watchdog oscillator whatever the source.
// - Fuse code 0000 takes the clock straight from the crystal input pin.
// - External clock wakes in 6 cycles; reset delay none/4K/64K; 11 reserved.
// - Short reset delay is 4096, long is 65536 watchdog cycles.
// - Fuse bit one means unprogrammed, zero means programmed.
//
// The register offsets and the strobed register port are this design's own decisions.
`include "csss_regs.svh"

module csss_top
#(
	parameter int LONG_RST_WDT_CYC  = `CSS_RST_64K_DEF,
	parameter int LONG_WAKE_SRC_CYC = `CSS_WAKE_32K_DEF
)
(
	input  wire logic                   CLK_I,
	input  wire logic                   RSTN_I,
	input  wire logic             [3:0] CLK_SRC_SEL_FUSES_I,
	input  wire logic             [1:0] STARTUP_TIME_FUSES_I,
	input  wire logic                   OSC_OPTION_FUSE_I,
	input  wire logic             [7:0] SIG_BYTE_I,
	input  wire logic                   SRC_TICK_I,
	input  wire logic                   WDOG_TICK_I,
	input  wire logic                   SLEEP_I,
	input  wire logic                   WAKE_I,
	input  wire logic [`CSS_ADDR_W-1:0] ADDR_I,
	input  wire logic             [7:0] WDATA_I,
	input  wire logic                   WE_I,
	input  wire logic                   RE_I,
	output logic                  [7:0] RDATA_O,
	output logic                  [7:0] TRIM_O,
	output csss_pkg::csss_src_t         SRC_SEL_O,
	output logic                  [1:0] FREQ_RANGE_O,
	output logic                        INT_CAP_EN_O,
	output logic                        CFG_ERR_O,
	output logic                        CLK_RELEASE_O,
	output logic                        RST_DELAY_O,
	output logic                        SIG_RD_O,
	output logic                  [7:0] SIG_ADDR_O
);
	import csss_pkg::*;

	localparam logic [`CSS_CNT_W-1:0] RST_LONG_CNT  = LONG_RST_WDT_CYC[`CSS_CNT_W-1:0];
	localparam logic [`CSS_CNT_W-1:0] WAKE_LONG_CNT = LONG_WAKE_SRC_CYC[`CSS_CNT_W-1:0];

	localparam csss_top_st_t RST_ST = '{
		st:          ST_LOAD,
		clock_source_select_fuses:       `CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_LO,
		startup_time_fuses:         `CSS_SUT_10,
		oscillator_option_fuse:       ~`CSS_FUSE_PROG,
		trim:        `CSS_TRIM_RST,
		rdata:       `CSS_DATA_ZERO,
		src:         SRC_NONE,
		freq:        `CSS_FREQ_ZERO,
		cap_en:      1'b0,
		err:         1'b0,
		release_clk: 1'b0,
		rst_delay:   1'b0,
		sig_rd:      1'b1,
		sig_addr:    `CSS_SIG_TRIM_ADDR,
		cnt_start:   1'b0
	};

	csss_top_st_t          s_reg;
	csss_top_st_t          s_next;
	csss_src_t             dec_src;
	logic            [1:0] dec_freq;
	csss_wake_t            dec_wake;
	csss_rst_t             dec_rst;
	logic                  dec_err;
	logic [`CSS_CNT_W-1:0] rst_cyc;
	logic [`CSS_CNT_W-1:0] wake_cyc;
	logic                  cnt_tick;
	logic [`CSS_CNT_W-1:0] cnt_load;
	logic                  cnt_busy;
	logic                  cnt_done;

	// ----------------------------------------------------------------
	// Fuse decode of the latched fuse image
	// ----------------------------------------------------------------
	csss_fuse_decode u_dec
	(
		.clock_source_select_fuses_i (s_reg.clock_source_select_fuses),
		.sut_i   (s_reg.startup_time_fuses),
		.src_o   (dec_src),
		.freq_o  (dec_freq),
		.wake_o  (dec_wake),
		.rst_o   (dec_rst),
		.err_o   (dec_err)
	);

	// Delay kinds to cycle counts
	always_comb
	begin
		unique case (dec_rst)
			RK_NONE:  rst_cyc = `CSS_RST_NONE;
			RK_SHORT: rst_cyc = `CSS_RST_4K;
			RK_LONG:  rst_cyc = RST_LONG_CNT;
		endcase
		unique case (dec_wake)
			WK_6:   wake_cyc = `CSS_WAKE_6;
			WK_18:  wake_cyc = `CSS_WAKE_18;
			WK_1K:  wake_cyc = `CSS_WAKE_1K;
			WK_32K: wake_cyc = WAKE_LONG_CNT;
		endcase
	end

	// ----------------------------------------------------------------
	// Shared delay counter
	// ----------------------------------------------------------------
	// Reset delay always runs on the watchdog oscillator tick
	assign cnt_tick = (s_reg.st == ST_RST_WAIT) ? WDOG_TICK_I : SRC_TICK_I;
	assign cnt_load = (s_reg.st == ST_RST_WAIT) ? rst_cyc : wake_cyc;

	csss_delay_cnt u_cnt
	(
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.start_i (s_reg.cnt_start),
		.load_i  (cnt_load),
		.tick_i  (cnt_tick),
		.busy_o  (cnt_busy),
		.done_o  (cnt_done)
	);

	// ----------------------------------------------------------------
	// Sequencer, register port and outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next           = s_reg;
		s_next.cnt_start = 1'b0;
		s_next.rdata     = `CSS_DATA_ZERO;
		// Software trim write, drives the oscillator directly
		if (WE_I && ADDR_I == `CSS_REG_TRIM)
			s_next.trim = WDATA_I;
		unique case (s_reg.st)
			ST_LOAD:
			begin
				s_next.clock_source_select_fuses     = CLK_SRC_SEL_FUSES_I;
				s_next.startup_time_fuses       = STARTUP_TIME_FUSES_I;
				s_next.oscillator_option_fuse     = OSC_OPTION_FUSE_I;
				s_next.trim      = SIG_BYTE_I;
				s_next.st        = ST_RST_WAIT;
				s_next.cnt_start = 1'b1;
			end
			ST_RST_WAIT:
			begin
				if (dec_err)
					s_next.st = ST_HOLD;
				else if (cnt_done)
				begin
					s_next.st        = ST_WAKE_WAIT;
					s_next.cnt_start = 1'b1;
				end
			end
			ST_WAKE_WAIT:
			begin
				if (cnt_done)
					s_next.st = ST_RUN;
			end
			ST_RUN:
			begin
				if (SLEEP_I)
					s_next.st = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if (WAKE_I)
				begin
					s_next.st        = ST_WAKE_WAIT;
					s_next.cnt_start = 1'b1;
				end
			end
			ST_HOLD:
			begin
				s_next.st = ST_HOLD;
			end
		endcase
		// Read data for the cycle after the strobe
		if (RE_I)
		begin
			unique case (ADDR_I)
				`CSS_REG_TRIM: s_next.rdata = s_reg.trim;
				`CSS_REG_STAT: s_next.rdata = {s_reg.err, s_reg.src, s_reg.freq};
				`CSS_REG_FUSE: s_next.rdata = {s_reg.release_clk, s_reg.oscillator_option_fuse,
				                               s_reg.startup_time_fuses, s_reg.clock_source_select_fuses};
				default:       s_next.rdata = `CSS_DATA_ZERO;
			endcase
		end
		s_next.src  = dec_src;
		s_next.freq = dec_freq;
		s_next.err  = dec_err;
		// Capacitors on programmed option fuse, never for internal RC or with no source
		s_next.cap_en = (s_reg.oscillator_option_fuse == `CSS_FUSE_PROG) && (dec_src != SRC_NONE) &&
		                (dec_src != SRC_INTRC);
		s_next.release_clk = (s_next.st == ST_RUN);
		s_next.rst_delay   = (s_next.st == ST_RST_WAIT);
		s_next.sig_rd      = (s_next.st == ST_LOAD);
		s_next.sig_addr    = `CSS_SIG_TRIM_ADDR;
	end

	// State register
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I)
			s_reg <= RST_ST;
		else
			s_reg <= s_next;
	end

	assign RDATA_O       = s_reg.rdata;
	assign TRIM_O        = s_reg.trim;
	assign SRC_SEL_O     = s_reg.src;
	assign FREQ_RANGE_O  = s_reg.freq;
	assign INT_CAP_EN_O  = s_reg.cap_en;
	assign CFG_ERR_O     = s_reg.err;
	assign CLK_RELEASE_O = s_reg.release_clk;
	assign RST_DELAY_O   = s_reg.rst_delay;
	assign SIG_RD_O      = s_reg.sig_rd;
	assign SIG_ADDR_O    = s_reg.sig_addr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [`CSS_CNT_W-1:0] wdt_seen;
	logic [`CSS_CNT_W-1:0] src_seen;

	// Counted ticks inside each wait phase
	always_ff @(posedge CLK_I)
	begin
		if (!RSTN_I || s_reg.cnt_start)
		begin
			wdt_seen <= `CSS_CNT_ZERO;
			src_seen <= `CSS_CNT_ZERO;
		end
		else if (cnt_busy)
		begin
			if (WDOG_TICK_I && s_reg.st == ST_RST_WAIT)
				wdt_seen <= wdt_seen + `CSS_CNT_ONE;
			if (SRC_TICK_I && s_reg.st == ST_WAKE_WAIT)
				src_seen <= src_seen + `CSS_CNT_ONE;
		end
	end

	sequence seq_rst_over;
		$past(RSTN_I) && $past(s_reg.st) == ST_RST_WAIT && s_reg.st == ST_WAKE_WAIT;
	endsequence

	sequence seq_wake_over;
		$past(RSTN_I) && $past(s_reg.st) == ST_WAKE_WAIT && s_reg.st == ST_RUN;
	endsequence

	AST_LFXTAL_SRC: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_RUN && s_reg.clock_source_select_fuses == `CSS_CLOCK_SOURCE_SELECT_FUSES_LFXTAL |-> SRC_SEL_O == SRC_LFXTAL)
		else $error("watch crystal code not selecting crystal");

	AST_CAP_EN: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_RUN && SRC_SEL_O == SRC_LFXTAL |->
		INT_CAP_EN_O == (s_reg.oscillator_option_fuse == `CSS_FUSE_PROG))
		else $error("crystal capacitors not following option fuse");

	AST_EXTRC_RANGE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_RUN && SRC_SEL_O == SRC_EXTRC |->
		FREQ_RANGE_O == rc_range(s_reg.clock_source_select_fuses))
		else $error("external RC range wrong");

	AST_INTRC_SEL: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_RUN && s_reg.clock_source_select_fuses == `CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_HI |->
		SRC_SEL_O == SRC_INTRC && FREQ_RANGE_O == 2'h3 && !INT_CAP_EN_O)
		else $error("internal RC top code wrong");

	AST_EXTCLK_SEL: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_RUN && s_reg.clock_source_select_fuses == `CSS_CLOCK_SOURCE_SELECT_FUSES_EXTCLK |-> SRC_SEL_O == SRC_EXTCLK)
		else $error("external clock code not selecting pin");

	AST_TRIM_LOAD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_LOAD && SIG_RD_O |=> TRIM_O == $past(SIG_BYTE_I) && RST_DELAY_O)
		else $error("trim not loaded from signature byte");

	AST_RST_COUNT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		seq_rst_over |-> wdt_seen == $past(rst_cyc))
		else $error("reset delay watchdog count wrong");

	AST_WAKE_COUNT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		seq_wake_over |-> src_seen == $past(wake_cyc) && CLK_RELEASE_O)
		else $error("wake delay source count wrong");

	AST_RELEASE_CAUSE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		$rose(CLK_RELEASE_O) |-> $past(s_reg.st) == ST_WAKE_WAIT && $past(cnt_done))
		else $error("clock released outside wake delay");

	AST_RESERVED_HOLD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		CFG_ERR_O && s_reg.st != ST_LOAD |-> ##[1:2] (s_reg.st == ST_HOLD && !CLK_RELEASE_O))
		else $error("reserved start-up code not held");

	AST_INTRC_WAKE6: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		s_reg.st == ST_WAKE_WAIT && (SRC_SEL_O == SRC_INTRC || SRC_SEL_O == SRC_EXTCLK) |->
		wake_cyc == `CSS_WAKE_6)
		else $error("six cycle wake delay wrong");

	// Expected external RC range index
	// Low code bits rotated: 0101 -> 0, 0110 -> 1, 0111 -> 2, 1000 -> 3
	function automatic logic [1:0] rc_range(input logic [3:0] code);
		return code[1:0] + 2'h3;
	endfunction : rc_range

endmodule : csss_top

// file: verilog/csss_regs.svh
`ifndef CSSS_REGS_SVH
`define CSSS_REGS_SVH

// ----------------------------------------------------------------
// Register map (index on the plain register port)
// ----------------------------------------------------------------
`define CSS_ADDR_W          2
`define CSS_REG_TRIM        2'h0
`define CSS_REG_STAT        2'h1
`define CSS_REG_FUSE        2'h2
`define CSS_DATA_ZERO       8'h00

// ----------------------------------------------------------------
// Fuse codes as read (1 = unprogrammed, 0 = programmed)
// ----------------------------------------------------------------
`define CSS_CLOCK_SOURCE_SELECT_FUSES_EXTCLK    4'h0
`define CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_LO  4'h1
`define CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_HI  4'h4
`define CSS_CLOCK_SOURCE_SELECT_FUSES_EXTRC_LO  4'h5
`define CSS_CLOCK_SOURCE_SELECT_FUSES_EXTRC_HI  4'h8
`define CSS_CLOCK_SOURCE_SELECT_FUSES_LFXTAL    4'h9
`define CSS_SUT_00          2'h0
`define CSS_SUT_01          2'h1
`define CSS_SUT_10          2'h2
`define CSS_SUT_11          2'h3
`define CSS_FUSE_PROG       1'b0
`define CSS_FREQ_ZERO       2'h0

// ----------------------------------------------------------------
// Delay counts
// ----------------------------------------------------------------
`define CSS_CNT_W           17
`define CSS_CNT_ZERO        17'h00000
`define CSS_CNT_ONE         17'h00001
`define CSS_WAKE_6          17'h00006
`define CSS_WAKE_18         17'h00012
`define CSS_WAKE_1K         17'h00400
`define CSS_RST_NONE        17'h00000
`define CSS_RST_4K          17'h01000
`define CSS_RST_64K_DEF     65536
`define CSS_WAKE_32K_DEF    32768

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSS_TRIM_RST        8'h00
`define CSS_SIG_TRIM_ADDR   8'h00

`endif

// file: verilog/csss_pkg.sv
`include "csss_regs.svh"

package csss_pkg;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [4:0]
	{
		SRC_NONE   = 5'h01,
		SRC_EXTCLK = 5'h02,
		SRC_INTRC  = 5'h04,
		SRC_EXTRC  = 5'h08,
		SRC_LFXTAL = 5'h10
	} csss_src_t;

	typedef enum logic [3:0]
	{
		WK_6   = 4'h1,
		WK_18  = 4'h2,
		WK_1K  = 4'h4,
		WK_32K = 4'h8
	} csss_wake_t;

	typedef enum logic [2:0]
	{
		RK_NONE  = 3'h1,
		RK_SHORT = 3'h2,
		RK_LONG  = 3'h4
	} csss_rst_t;

	typedef enum logic [5:0]
	{
		ST_LOAD      = 6'h01,
		ST_RST_WAIT  = 6'h02,
		ST_WAKE_WAIT = 6'h04,
		ST_RUN       = 6'h08,
		ST_SLEEP     = 6'h10,
		ST_HOLD      = 6'h20
	} csss_state_t;

	// ----------------------------------------------------------------
	// State records
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [`CSS_CNT_W-1:0] cnt;
		logic                  busy;
		logic                  done;
	} csss_cnt_st_t;

	typedef struct packed
	{
		csss_state_t st;
		logic [3:0]  clock_source_select_fuses;
		logic [1:0]  startup_time_fuses;
		logic        oscillator_option_fuse;
		logic [7:0]  trim;
		logic [7:0]  rdata;
		csss_src_t   src;
		logic [1:0]  freq;
		logic        cap_en;
		logic        err;
		logic        release_clk;
		logic        rst_delay;
		logic        sig_rd;
		logic [7:0]  sig_addr;
		logic        cnt_start;
	} csss_top_st_t;

endpackage : csss_pkg

// file: verilog/csss_delay_cnt.sv
`include "csss_regs.svh"

module csss_delay_cnt
(
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  start_i,
	input  wire logic [`CSS_CNT_W-1:0] load_i,
	input  wire logic                  tick_i,
	output logic                       busy_o,
	output logic                       done_o
);
	import csss_pkg::*;

	csss_cnt_st_t s_reg;
	csss_cnt_st_t s_next;

	// ----------------------------------------------------------------
	// Down counter on tick enable
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (start_i)
		begin
			s_next.cnt  = load_i;
			s_next.busy = (load_i != `CSS_CNT_ZERO);
			s_next.done = (load_i == `CSS_CNT_ZERO);
		end
		else if (s_reg.busy && tick_i)
		begin
			s_next.cnt = s_reg.cnt - `CSS_CNT_ONE;
			if (s_reg.cnt == `CSS_CNT_ONE)
			begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end
		end
	end

	// Register
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			s_reg <= '{cnt: `CSS_CNT_ZERO, busy: 1'b0, done: 1'b0};
		else
			s_reg <= s_next;
	end

	assign busy_o = s_reg.busy;
	assign done_o = s_reg.done;

endmodule : csss_delay_cnt

// file: verilog/csss_fuse_decode.sv
`include "csss_regs.svh"

module csss_fuse_decode
(
	input  wire logic       [3:0] clock_source_select_fuses_i,
	input  wire logic       [1:0] sut_i,
	output csss_pkg::csss_src_t   src_o,
	output logic            [1:0] freq_o,
	output csss_pkg::csss_wake_t  wake_o,
	output csss_pkg::csss_rst_t   rst_o,
	output logic                  err_o
);
	import csss_pkg::*;

	logic [3:0] rc_off;
	logic [3:0] ic_off;

	// Range index inside each source group
	assign rc_off = clock_source_select_fuses_i - `CSS_CLOCK_SOURCE_SELECT_FUSES_EXTRC_LO;
	assign ic_off = clock_source_select_fuses_i - `CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_LO;

	// ----------------------------------------------------------------
	// Source and start-up decode
	// ----------------------------------------------------------------
	always_comb
	begin
		src_o  = SRC_NONE;
		freq_o = `CSS_FREQ_ZERO;
		wake_o = WK_6;
		rst_o  = RK_NONE;
		err_o  = 1'b1;
		if (clock_source_select_fuses_i == `CSS_CLOCK_SOURCE_SELECT_FUSES_LFXTAL)
		begin
			src_o = SRC_LFXTAL;
			unique case (sut_i)
				`CSS_SUT_00: begin wake_o = WK_1K;  rst_o = RK_SHORT; err_o = 1'b0; end
				`CSS_SUT_01: begin wake_o = WK_1K;  rst_o = RK_LONG;  err_o = 1'b0; end
				`CSS_SUT_10: begin wake_o = WK_32K; rst_o = RK_LONG;  err_o = 1'b0; end
				`CSS_SUT_11: err_o = 1'b1;
			endcase
		end
		else if (clock_source_select_fuses_i >= `CSS_CLOCK_SOURCE_SELECT_FUSES_EXTRC_LO && clock_source_select_fuses_i <= `CSS_CLOCK_SOURCE_SELECT_FUSES_EXTRC_HI)
		begin
			src_o  = SRC_EXTRC;
			freq_o = rc_off[1:0];
			err_o  = 1'b0;
			unique case (sut_i)
				`CSS_SUT_00: begin wake_o = WK_18; rst_o = RK_NONE;  end
				`CSS_SUT_01: begin wake_o = WK_18; rst_o = RK_SHORT; end
				`CSS_SUT_10: begin wake_o = WK_18; rst_o = RK_LONG;  end
				`CSS_SUT_11: begin wake_o = WK_6;  rst_o = RK_SHORT; end
			endcase
		end
		else if (clock_source_select_fuses_i >= `CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_LO && clock_source_select_fuses_i <= `CSS_CLOCK_SOURCE_SELECT_FUSES_INTRC_HI)
		begin
			src_o  = SRC_INTRC;
			freq_o = ic_off[1:0];
			unique case (sut_i)
				`CSS_SUT_00: begin rst_o = RK_NONE;  err_o = 1'b0; end
				`CSS_SUT_01: begin rst_o = RK_SHORT; err_o = 1'b0; end
				`CSS_SUT_10: begin rst_o = RK_LONG;  err_o = 1'b0; end
				`CSS_SUT_11: err_o = 1'b1;
			endcase
		end
		else if (clock_source_select_fuses_i == `CSS_CLOCK_SOURCE_SELECT_FUSES_EXTCLK)
		begin
			src_o = SRC_EXTCLK;
			unique case (sut_i)
				`CSS_SUT_00: begin rst_o = RK_NONE;  err_o = 1'b0; end
				`CSS_SUT_01: begin rst_o = RK_SHORT; err_o = 1'b0; end
				`CSS_SUT_10: begin rst_o = RK_LONG;  err_o = 1'b0; end
				`CSS_SUT_11: err_o = 1'b1;
			endcase
		end
	end

endmodule : csss_fuse_decode

// file: verilog/csss_delay_cnt_fix.sv
// (intentionally empty)

// file: dv/csss_top_bench.sv
`include "csss_regs.svh"

module csss_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import csss_pkg::*;

	// Shortened long counts handed to the design
	localparam int RST_LONG  = 64;
	localparam int WAKE_LONG = 40;

	logic                   CLK_I                = 1'h0;
	logic                   RSTN_I               = 1'h0;
	logic             [3:0] CLK_SRC_SEL_FUSES_I  = 4'h1;
	logic             [1:0] STARTUP_TIME_FUSES_I = 2'h2;
	logic                   OSC_OPTION_FUSE_I    = 1'h1;
	logic             [7:0] SIG_BYTE_I           = 8'h00;
	logic                   SRC_TICK_I           = 1'h0;
	logic                   WDOG_TICK_I          = 1'h0;
	logic                   SLEEP_I              = 1'h0;
	logic                   WAKE_I               = 1'h0;
	logic [`CSS_ADDR_W-1:0] ADDR_I               = 2'h0;
	logic             [7:0] WDATA_I              = 8'h00;
	logic                   WE_I                 = 1'h0;
	logic                   RE_I                 = 1'h0;
	logic             [7:0] RDATA_O;
	logic             [7:0] TRIM_O;
	csss_src_t              SRC_SEL_O;
	logic             [1:0] FREQ_RANGE_O;
	logic                   INT_CAP_EN_O;
	logic                   CFG_ERR_O;
	logic                   CLK_RELEASE_O;
	logic                   RST_DELAY_O;
	logic                   SIG_RD_O;
	logic             [7:0] SIG_ADDR_O;
	int                     num_errors           = 0;
	int                     comparisons          = 0;
	logic             [7:0] last_sig;
	logic             [7:0] d;
	int                     n;

	// Fixed-rate clock, never varied while out of reset
	always #5 CLK_I = ~CLK_I;

	csss_top #(.LONG_RST_WDT_CYC(RST_LONG), .LONG_WAKE_SRC_CYC(WAKE_LONG)) uut
	(
		.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CLK_SRC_SEL_FUSES_I(CLK_SRC_SEL_FUSES_I),
		.STARTUP_TIME_FUSES_I(STARTUP_TIME_FUSES_I), .OSC_OPTION_FUSE_I(OSC_OPTION_FUSE_I),
		.SIG_BYTE_I(SIG_BYTE_I), .SRC_TICK_I(SRC_TICK_I), .WDOG_TICK_I(WDOG_TICK_I),
		.SLEEP_I(SLEEP_I), .WAKE_I(WAKE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .TRIM_O(TRIM_O),
		.SRC_SEL_O(SRC_SEL_O), .FREQ_RANGE_O(FREQ_RANGE_O), .INT_CAP_EN_O(INT_CAP_EN_O),
		.CFG_ERR_O(CFG_ERR_O), .CLK_RELEASE_O(CLK_RELEASE_O), .RST_DELAY_O(RST_DELAY_O),
		.SIG_RD_O(SIG_RD_O), .SIG_ADDR_O(SIG_ADDR_O)
	);

	// ----------------------------------------------------------------
	// Helper tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge CLK_I);
		ADDR_I  <= a;
		WDATA_I <= v;
		WE_I    <= 1'h1;
		@(posedge CLK_I);
		WE_I    <= 1'h0;
		#1;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge CLK_I);
		ADDR_I <= a;
		RE_I   <= 1'h1;
		@(posedge CLK_I);
		RE_I   <= 1'h0;
		#1;
		v = RDATA_O;
	endtask : rd

	// One-cycle sleep (s=1) or wake (s=0) request
	task automatic pulse(input bit s);
		@(posedge CLK_I);
		SLEEP_I <= s;
		WAKE_I  <= !s;
		@(posedge CLK_I);
		SLEEP_I <= 1'h0;
		WAKE_I  <= 1'h0;
		repeat (2) @(posedge CLK_I);
		#1;
	endtask : pulse

	// Feeds spaced ticks until the phase ends; wd picks the watchdog ticks
	task automatic count_ticks(input bit wd, output int cnt);
		cnt = 0;
		repeat (3) @(posedge CLK_I);
		for (int i = 0; i < 5000; i++)
		begin
			#1;
			if (wd ? (RST_DELAY_O === 1'h0) : (CLK_RELEASE_O === 1'h1))
				return;
			@(posedge CLK_I);
			WDOG_TICK_I <= wd;
			SRC_TICK_I  <= !wd;
			@(posedge CLK_I);
			WDOG_TICK_I <= 1'h0;
			SRC_TICK_I  <= 1'h0;
			cnt++;
			repeat (3) @(posedge CLK_I);
		end
		$display("ERROR tick wait expected end seen none");
		num_errors++;
		close_out();
	endtask : count_ticks

	// Boots with one fuse image and checks decode, delays and registers
	task automatic run_case(input logic [3:0] cs, input logic [1:0] su, input logic op,
		input logic [4:0] src, input logic [1:0] fr, input logic er, input logic cap,
		input int rst_n, input int wake_n);
		logic [7:0] v;
		int         k;
		@(posedge CLK_I);
		RSTN_I               <= 1'h0;
		CLK_SRC_SEL_FUSES_I  <= cs;
		STARTUP_TIME_FUSES_I <= su;
		OSC_OPTION_FUSE_I    <= op;
		last_sig             = {su, op, 1'h1, cs} ^ 8'h5A;
		SIG_BYTE_I           <= last_sig;
		repeat (4) @(posedge CLK_I);
		#1;
		chk("sig_rd", 32'h1, SIG_RD_O);
		chk("sig_addr", 32'h0, SIG_ADDR_O);
		@(posedge CLK_I);
		RSTN_I <= 1'h1;
		for (int i = 0; i < 10 && RST_DELAY_O !== 1'h1; i++)
		begin
			@(posedge CLK_I);
			#1;
		end
		chk("rst_delay", 32'h1, RST_DELAY_O);
		// Reset delay never started: report and end the whole simulation
		if (RST_DELAY_O !== 1'h1)
			close_out();
		chk("trim", last_sig, TRIM_O);
		if (er)
		begin
			@(posedge CLK_I);
			WDOG_TICK_I <= 1'h1;
			SRC_TICK_I  <= 1'h1;
			repeat (80) @(posedge CLK_I);
			WDOG_TICK_I <= 1'h0;
			SRC_TICK_I  <= 1'h0;
			#1;
			chk("cfg_err", 32'h1, CFG_ERR_O);
			chk("release", 32'h0, CLK_RELEASE_O);
			return;
		end
		count_ticks(1'h1, k);
		chk("rst_ticks", rst_n, k);
		chk("src", src, SRC_SEL_O);
		chk("freq", fr, FREQ_RANGE_O);
		chk("cfg_err", 32'h0, CFG_ERR_O);
		chk("cap", cap, INT_CAP_EN_O);
		count_ticks(1'h0, k);
		chk("wake_ticks", wake_n, k);
		rd(2'h1, v);
		chk("status", {er, src, fr}, v);
		rd(2'h2, v);
		chk("fuse_reg", {1'h1, op, su, cs}, v);
	endtask : run_case

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		run_case(4'h1, 2'h2, 1'h1, 5'h04, 2'h0, 1'h0, 1'h0, RST_LONG, 6);
		run_case(4'h4, 2'h0, 1'h1, 5'h04, 2'h3, 1'h0, 1'h0, 0, 6);
		run_case(4'h3, 2'h1, 1'h1, 5'h04, 2'h2, 1'h0, 1'h0, 4096, 6);
		run_case(4'h2, 2'h3, 1'h1, 5'h04, 2'h1, 1'h1, 1'h0, 0, 0);
		run_case(4'h0, 2'h0, 1'h0, 5'h02, 2'h0, 1'h0, 1'h1, 0, 6);
		run_case(4'h0, 2'h2, 1'h1, 5'h02, 2'h0, 1'h0, 1'h0, RST_LONG, 6);
		run_case(4'h0, 2'h3, 1'h1, 5'h02, 2'h0, 1'h1, 1'h0, 0, 0);
		run_case(4'h5, 2'h3, 1'h0, 5'h08, 2'h0, 1'h0, 1'h1, 4096, 6);
		run_case(4'h8, 2'h0, 1'h1, 5'h08, 2'h3, 1'h0, 1'h0, 0, 18);
		run_case(4'h6, 2'h2, 1'h1, 5'h08, 2'h1, 1'h0, 1'h0, RST_LONG, 18);
		run_case(4'hA, 2'h0, 1'h1, 5'h01, 2'h0, 1'h1, 1'h0, 0, 0);
		run_case(4'h9, 2'h3, 1'h1, 5'h10, 2'h0, 1'h1, 1'h0, 0, 0);
		run_case(4'h9, 2'h1, 1'h0, 5'h10, 2'h0, 1'h0, 1'h1, RST_LONG, 1024);
		run_case(4'h9, 2'h2, 1'h1, 5'h10, 2'h0, 1'h0, 1'h0, RST_LONG, WAKE_LONG);
		// Trim register access, read-only and unmapped places
		rd(2'h0, d);
		chk("trim_rd", last_sig, d);
		@(posedge CLK_I);
		#1;
		chk("rdata_idle", 32'h0, RDATA_O);
		wr(2'h0, 8'h00);
		chk("trim_out", 32'h00, TRIM_O);
		wr(2'h0, 8'hFF);
		chk("trim_out", 32'hFF, TRIM_O);
		wr(2'h1, 8'h00);
		wr(2'h2, 8'h00);
		wr(2'h3, 8'h5A);
		rd(2'h3, d);
		chk("unmapped", 32'h0, d);
		rd(2'h0, d);
		chk("trim_rd", 32'hFF, d);
		rd(2'h2, d);
		chk("fuse_reg", {1'h1, 1'h1, 2'h2, 4'h9}, d);
		// Sleep and wake: source cycles only, no reset delay
		pulse(1'h0);
		chk("wake_in_run", 32'h1, CLK_RELEASE_O);
		pulse(1'h1);
		chk("sleep", 32'h0, CLK_RELEASE_O);
		pulse(1'h0);
		chk("no_rst_delay", 32'h0, RST_DELAY_O);
		count_ticks(1'h0, n);
		chk("wake_ticks", WAKE_LONG, n);
		close_out();
	end

endmodule : csss_top_bench
